// *** testbench/cpu_side_model.sv ***
// Purpose: Processor side: issues vector fetches on command
// Assumes: One fetch per command, then the register save
// Notes:   Group field toggles while idle so stale values never pass
`timescale 1ns/1ps
module cpu_side_model (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Command and fetch port
    input  wire logic                  cmd_go,
    input  wire logic [3:0]            cmd_grp,
    input  irq_expand_pkg::vec_rsp_t   vec_rsp,
    output irq_expand_pkg::vec_req_t   vec_req,
    output irq_expand_pkg::vec_rsp_t   last_rsp,
    output logic [7:0]                 n_served
);
    logic [3:0] save_cnt;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vec_req  <= '0;
            save_cnt <= 4'h0;
        end
        else
        begin
            vec_req <= {1'b0, ~vec_req.group};
            if (save_cnt != 4'h0)
                save_cnt <= save_cnt - 4'h1;
            // Busy saving registers: no new fetch for nine cycles
            if (cmd_go && save_cnt == 4'h0)
            begin
                vec_req  <= {1'b1, cmd_grp};
                save_cnt <= 4'h9;
            end
        end
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            last_rsp <= '0;
            n_served <= 8'h00;
        end
        else if (vec_rsp.valid)
        begin
            last_rsp <= vec_rsp;
            n_served <= n_served + 8'h01;
        end
    end
endmodule // cpu_side_model

// *** testbench/interrupt_expansion_ext_irq_tb.sv ***
// Purpose: Self-checking bench for the interrupt expander
// Assumes: Default parameters
// Notes:   Wake and nmi pulses are counted in the background
`timescale 1ns/1ps
`include "irq_expand_defs.svh"
module interrupt_expansion_ext_irq_tb;
    logic                      clk, rst, reg_wr, reg_rd, cmd_go, irq, cpu_nmi, cpu_wake, line13, line14;
    logic                      timer0_irq, timer1_irq, timer2_irq, ext_irq_one, ext_irq_two, shared_nmi_irq_pin;
    logic [11:0]               reg_addr, cpu_irq_grouped;
    logic [31:0]               reg_wdata, reg_rdata, d;
    logic [95:0]               periph_irq;
    logic [3:0]                cmd_grp;
    logic [7:0]                n_served;
    irq_expand_pkg::vec_req_t  vec_req;
    irq_expand_pkg::vec_rsp_t  vec_rsp, last_rsp;
    int                        err_total, n_tests, cyc, n_wake, n_nmi;

    irq_expand_top u_irq_expand_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_irq(periph_irq),
        .timer0_irq(timer0_irq), .timer1_irq(timer1_irq), .timer2_irq(timer2_irq), .ext_irq_one(ext_irq_one),
        .ext_irq_two(ext_irq_two), .shared_nmi_irq_pin(shared_nmi_irq_pin),
        .cpu_irq_grouped(cpu_irq_grouped), .cpu_irq_line_thirteen(line13), .cpu_irq_line_fourteen(line14),
        .cpu_nmi(cpu_nmi), .vec_req(vec_req), .vec_rsp(vec_rsp), .cpu_wake(cpu_wake), .irq(irq));
    cpu_side_model u_cpu_side_model (.clk(clk), .rst(rst), .cmd_go(cmd_go), .cmd_grp(cmd_grp),
        .vec_rsp(vec_rsp), .vec_req(vec_req), .last_rsp(last_rsp), .n_served(n_served));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        n_wake += (cpu_wake === 1'b1);
        n_nmi += (cpu_nmi === 1'b1);
        cyc++;
        // Whole run needs well under 2000 cycles
        if (cyc == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk) reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
        check(d, e);
    endtask
    task automatic pulse(input logic [95:0] v);
        @(posedge clk) periph_irq <= v;
        @(posedge clk) periph_irq <= '0;
        #1;
    endtask
    task automatic fetch(input logic [3:0] g);
        @(posedge clk) {cmd_go, cmd_grp} <= {1'b1, g};
        @(posedge clk) cmd_go <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic tog2;
        @(posedge clk) ext_irq_two <= ~ext_irq_two;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic t_regs;
        rdc(`REG_LP_MODE, 32'h0000_0000);
        rdc(`REG_VEC_BASE, 32'h0000_0000);
        wr(`REG_IRQ_MASK, 32'hFFFF_FFFF);
        rdc(`REG_IRQ_MASK, 32'h0000_001F);
        rdc(12'h580, 32'h0000_0000);
    endtask
    task automatic t_fetch;
        wr(12'h424, 32'h0012_3456);
        rdc(12'h424, 32'h0012_3456);
        wr(12'h204, 32'h0000_0002);
        pulse(96'h300);
        check(cpu_irq_grouped, 12'h002);
        fetch(4'h1);
        check({last_rsp.source, last_rsp.vector}, {7'd9, 22'h12_3456});
        check(cpu_irq_grouped, 12'h000);
        wr(`REG_GROUP_ACK, 32'h0000_0002);
        wr(12'h204, 32'h0000_0003);
        check(cpu_irq_grouped, 12'h002);
        fetch(4'h1);
        check({last_rsp.source, last_rsp.vector}, {7'd8, 22'h00_0000});
        fetch(4'h2);
        check(last_rsp.vector, 22'h3F_FFFF);
        fetch(4'hC);
        check(n_served, 8'h03);
    endtask
    task automatic t_unused;
        wr(12'h214, 32'h0000_00FF);
        pulse(96'h0000_0000_0000_2000_0000_0000);
        check(cpu_irq_grouped, 12'h000);
        pulse(96'h0000_0000_0000_1000_0000_0000);
        check(cpu_irq_grouped, 12'h020);
        fetch(4'h5);
        check(last_rsp.source, 7'd44);
    endtask
    task automatic t_ext;
        wr(`REG_IRQ_MASK, 32'h0000_0001);
        wr(12'h100, 32'h0000_0003);
        @(posedge clk) ext_irq_one <= 1'b1;
        repeat (8) @(posedge clk);
        rdc(`REG_IRQ_STATUS, 32'h0000_0001);
        check(irq, 1'b1);
        // Stamp cleared at the third edge after the pin change, read nine and eleven edges later
        rdc(12'h140, 32'h0000_0008);
        rdc(12'h140, 32'h0000_000A);
        wr(`REG_IRQ_STATUS, 32'h0000_0001);
        check(irq, 1'b0);
        @(posedge clk) ext_irq_one <= 1'b0;
        repeat (8) @(posedge clk);
        wr(12'h100, 32'h0000_0002);
        @(posedge clk) ext_irq_one <= 1'b1;
        repeat (8) @(posedge clk);
        rdc(`REG_IRQ_STATUS, 32'h0000_0000);
        // A disabled edge must not restart the stamp
        rdc(12'h140, 32'h0000_0024);
    endtask
    task automatic t_wake;
        wr(12'h104, 32'h0000_0001);
        wr(`REG_LP_MODE, 32'h0000_0003);
        tog2();
        tog2();
        rdc(`REG_IRQ_STATUS, 32'h0000_0002);
        check(n_wake, 0);
        wr(12'h10C, 32'h0000_0003);
        @(posedge clk) shared_nmi_irq_pin <= 1'b1;
        repeat (8) @(posedge clk);
        check({n_wake[3:0], n_nmi[3:0]}, 8'h11);
        rdc(`REG_LP_MODE, 32'h0000_0000);
        wr(`REG_LP_MODE, 32'h0000_0002);
        tog2();
        check(n_wake, 1);
        tog2();
        check(n_wake, 2);
        wr(`REG_LP_MODE, 32'h0000_0001);
        pulse(96'h200);
        repeat (3) @(posedge clk);
        check(n_wake, 3);
        timer2_irq <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(line14, 1'b1);
        wr(12'h200, 32'h0000_0040);
        wr(`REG_LINE13_SEL, 32'h0000_0001);
        @(posedge clk) {timer0_irq, timer1_irq} <= 2'b11;
        @(posedge clk) timer0_irq <= 1'b0;
        @(posedge clk) #1 check({line13, cpu_irq_grouped}, 13'h1001);
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        {rst, reg_wr, reg_rd, cmd_go, timer0_irq, timer1_irq, timer2_irq} = 7'b1000000;
        {ext_irq_one, ext_irq_two, shared_nmi_irq_pin} = 3'b000;
        {reg_addr, reg_wdata, periph_irq, cmd_grp} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_fetch();
        t_unused();
        t_ext();
        t_wake();
        tally_and_finish();
    end
endmodule // interrupt_expansion_ext_irq_tb

bind irq_expand_top irq_expand_monitor u_irq_expand_monitor (.clk(clk), .rst(rst), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_irq_grouped(cpu_irq_grouped), .cpu_irq_line_fourteen(cpu_irq_line_fourteen),
    .timer2_irq(timer2_irq), .cpu_nmi(cpu_nmi), .cpu_wake(cpu_wake), .vec_req(vec_req), .vec_rsp(vec_rsp));

// *** testbench/irq_expand_monitor.sv ***
// Purpose: Port checker for the interrupt expander
// Assumes: Default USED_MASK, one clock domain
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`include "irq_expand_defs.svh"
module irq_expand_monitor (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Watched ports
    input  wire logic                  reg_rd,
    input  wire logic [31:0]           reg_rdata,
    input  wire logic [11:0]           cpu_irq_grouped,
    input  wire logic                  cpu_irq_line_fourteen,
    input  wire logic                  timer2_irq,
    input  wire logic                  cpu_nmi,
    input  wire logic                  cpu_wake,
    input  irq_expand_pkg::vec_req_t   vec_req,
    input  irq_expand_pkg::vec_rsp_t   vec_rsp
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence fetch_s;
        vec_req.req && vec_req.group < 4'hC;
    endsequence
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data without a read");
    fetch_ans_a: assert property (fetch_s |=> vec_rsp.valid)
        else $error("fetch not answered");
    fetch_refuse_a: assert property (!(vec_req.req && vec_req.group < 4'hC) |=> !vec_rsp.valid)
        else $error("answer without a fetch");
    fetch_drop_a: assert property (fetch_s |=> !cpu_irq_grouped[$past(vec_req.group)])
        else $error("line stays up after fetch");
    unused_grp_a: assert property (cpu_irq_grouped[11:6] == 6'h00)
        else $error("unused group asserted");
    line_fourteen_a: assert property (1'b1 |=> cpu_irq_line_fourteen == $past(timer2_irq))
        else $error("line fourteen wrong");
    nmi_pulse_a: assert property (cpu_nmi |=> !cpu_nmi)
        else $error("nmi longer than one cycle");
    wake_pulse_a: assert property (cpu_wake |=> !cpu_wake)
        else $error("wake longer than one cycle");
endmodule // irq_expand_monitor

// *** verilog/ext_irq_channel.sv ***
// Purpose: One external interrupt input: synchroniser, edge select, enable, time stamp
// Assumes: Pin is asynchronous to clk
// Notes:   Time stamp exists only when HAS_STAMP is set
`timescale 1ns/1ps
`include "irq_expand_defs.svh"

module ext_irq_channel #(
    parameter int HAS_STAMP = 1
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Pin and configuration
    input  wire logic                        pin,
    input  irq_expand_pkg::ext_cfg_t         cfg,
    // Results
    output logic                             edge_event,
    output logic [`IRQ_STAMP_W-1:0]          stamp
);

    logic sync_a;
    logic sync_b;
    logic last;
    logic valid_edge;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last   <= 1'b0;
        end
        else
        begin
            sync_a <= pin;
            sync_b <= sync_a;
            last   <= sync_b;
        end
    end

    // Only the second and third stages feed the detector, so one pin change gives one pulse
    assign valid_edge = cfg.rising ? (sync_b & ~last) : (~sync_b & last);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            edge_event <= 1'b0;
        else
            edge_event <= valid_edge & cfg.enable;
    end

    generate
        if (HAS_STAMP != 0)
        begin : g_stamp
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    stamp <= '0;
                else if (valid_edge & cfg.enable)
                    stamp <= '0;
                else
                    stamp <= stamp + 1'b1;
            end
        end
        else
        begin : g_no_stamp
            assign stamp = '0;
        end
    endgenerate

endmodule // ext_irq_channel

// *** verilog/irq_expand_defs.svh ***
// Purpose: Constants for the interrupt expansion and external interrupt block
// Assumes: Byte addressed register port, 32-bit data, one word per register
// Notes:   Offsets are byte addresses; every count is in system clock cycles
`ifndef IRQ_EXPAND_DEFS_SVH
`define IRQ_EXPAND_DEFS_SVH

`define IRQ_NUM_SOURCES    96
`define IRQ_NUM_GROUPS     12
`define IRQ_GROUP_SIZE     8
`define IRQ_USED_MASK      96'h0000_0000_0000_1FFF_FFFF_FFFF
`define IRQ_TIMER0_IDX     6
`define IRQ_EXT_ONE_IDX    3
`define IRQ_EXT_TWO_IDX    4
`define IRQ_NUM_EXT        4
`define IRQ_NMI_CH         3
`define IRQ_VEC_W          22
`define IRQ_STAMP_W        16
`define IRQ_ADDR_W         12
`define IRQ_DATA_W         32
`define IRQ_CPU_SAVE_CYC   9

`define REG_LP_MODE        12'h000
`define REG_IRQ_STATUS     12'h004
`define REG_IRQ_MASK       12'h008
`define REG_LINE13_SEL     12'h00C
`define REG_GROUP_ACK      12'h010
`define REG_EXT_CFG_BLK    6'h04
`define REG_EXT_STAMP_BLK  6'h05
`define REG_GRP_EN_BLK     6'h08
`define REG_GRP_FLAG_BLK   6'h09
`define REG_VEC_BASE       12'h400
`define REG_VEC_TOP        12'h57C

`define EXT_CFG_EN_BIT     0
`define EXT_CFG_RISE_BIT   1
`define ST_EXT_ONE_BIT     0
`define ST_EXT_TWO_BIT     1
`define ST_EXT_13_BIT      2
`define ST_NMI_BIT         3
`define ST_WAKE_BIT        4
`define ST_WIDTH           5

`define RST_VECTOR         22'h00_0000
`define RST_EMPTY_VECTOR   22'h3F_FFFF

`endif

// *** verilog/irq_expand_pkg.sv ***
// Purpose: Types shared by the interrupt expansion block and its edge channels
// Assumes: Constants come from irq_expand_defs.svh
// Notes:   Holds types only
`include "irq_expand_defs.svh"

package irq_expand_pkg;

    typedef enum logic [1:0]
    {
        LP_RUN     = 2'b00,
        LP_IDLE    = 2'b01,
        LP_STANDBY = 2'b10,
        LP_HALT    = 2'b11
    } lp_mode_t;

    typedef struct packed
    {
        logic rising;
        logic enable;
    } ext_cfg_t;

    typedef struct packed
    {
        logic       req;
        logic [3:0] group;
    } vec_req_t;

    typedef struct packed
    {
        logic                     valid;
        logic [6:0]               source;
        logic [`IRQ_VEC_W-1:0]    vector;
    } vec_rsp_t;

endpackage

// *** verilog/irq_expand_top.sv ***
// Purpose: Peripheral interrupt expander with external interrupts and wake-up logic
// Assumes: Peripheral requests are one-cycle pulses on clk; pins are asynchronous
// Notes:   Registers sit on a plain strobe port with read data one cycle later
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "irq_expand_defs.svh"

module irq_expand_top #(
    parameter logic [95:0]           USED_MASK    = `IRQ_USED_MASK,
    parameter logic [`IRQ_VEC_W-1:0] EMPTY_VECTOR = `RST_EMPTY_VECTOR
) (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Register port
    input  wire logic [`IRQ_ADDR_W-1:0]      reg_addr,
    input  wire logic [`IRQ_DATA_W-1:0]      reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [`IRQ_DATA_W-1:0]           reg_rdata,
    // Peripheral requests
    input  wire logic [`IRQ_NUM_SOURCES-1:0] periph_irq,
    input  wire logic                        timer0_irq,
    input  wire logic                        timer1_irq,
    input  wire logic                        timer2_irq,
    // External interrupt pins
    input  wire logic                        ext_irq_one,
    input  wire logic                        ext_irq_two,
    input  wire logic                        shared_nmi_irq_pin,
    // Processor side
    output logic [`IRQ_NUM_GROUPS-1:0]       cpu_irq_grouped,
    output logic                             cpu_irq_line_thirteen,
    output logic                             cpu_irq_line_fourteen,
    output logic                             cpu_nmi,
    input  irq_expand_pkg::vec_req_t         vec_req,
    output irq_expand_pkg::vec_rsp_t         vec_rsp,
    output logic                             cpu_wake,
    // Block interrupt
    output logic                             irq
);

    localparam int NG = `IRQ_NUM_GROUPS;
    localparam int GS = `IRQ_GROUP_SIZE;
    localparam int NE = `IRQ_NUM_EXT;

    logic [NG-1:0][GS-1:0]           grp_en;
    logic [NG-1:0][GS-1:0]           grp_flag;
    logic [NG-1:0]                   grp_ack;
    logic [`IRQ_VEC_W-1:0]           vec_ram [0:`IRQ_NUM_SOURCES-1];
    irq_expand_pkg::ext_cfg_t        ext_cfg [0:NE-1];
    logic [NE-1:0]                   ext_event;
    logic [`IRQ_STAMP_W-1:0]         ext_stamp [0:NE-1];
    logic [NE-1:0]                   ext_pins;
    irq_expand_pkg::lp_mode_t        lp_mode;
    logic [`ST_WIDTH-1:0]            irq_status;
    logic [`ST_WIDTH-1:0]            irq_mask;
    logic                            line13_sel_timer;
    logic                            ext13_pending;
    logic [`IRQ_NUM_SOURCES-1:0]     req_in;
    logic [`IRQ_NUM_SOURCES-1:0]     flag_flat;
    logic [`IRQ_NUM_SOURCES-1:0]     en_flat;
    logic [`IRQ_NUM_SOURCES-1:0]     set_flat;
    logic [`IRQ_NUM_SOURCES-1:0]     fetch_clr;
    logic [GS-1:0]                   win_onehot;
    logic [2:0]                      win_bit;
    logic                            win_any;
    logic                            fetch_ok;
    logic                            wake_now;
    logic [`ST_WIDTH-1:0]            status_set;

    // Returns the block index of a decoded window hit, or all ones when outside
    function automatic logic [4:0] blk_index(input logic [`IRQ_ADDR_W-1:0] a, input logic [5:0] blk,
                                             input int limit);
        logic [3:0] idx;
        idx = a[5:2];
        if (a[11:6] == blk && int'(idx) < limit)
            blk_index = {1'b0, idx};
        else
            blk_index = 5'h1F;
    endfunction

    function automatic logic vec_hit(input logic [`IRQ_ADDR_W-1:0] a);
        vec_hit = (a >= `REG_VEC_BASE) && (a <= `REG_VEC_TOP);
    endfunction

    // Request assembly: timer zero and the two plain external inputs join the groups
    always_comb
    begin
        req_in = periph_irq;
        req_in[`IRQ_TIMER0_IDX]  = periph_irq[`IRQ_TIMER0_IDX] | timer0_irq;
        req_in[`IRQ_EXT_ONE_IDX] = periph_irq[`IRQ_EXT_ONE_IDX] | ext_event[0];
        req_in[`IRQ_EXT_TWO_IDX] = periph_irq[`IRQ_EXT_TWO_IDX] | ext_event[1];
        set_flat = req_in & USED_MASK;
    end

    // External channels; the shared pin feeds both the third maskable and the non-maskable
    assign ext_pins = {shared_nmi_irq_pin, shared_nmi_irq_pin, ext_irq_two, ext_irq_one};

    generate
        for (genvar c = 0; c < NE; c++)
        begin : g_ext
            ext_irq_channel #(
                .HAS_STAMP (c != `IRQ_NMI_CH)
            ) u_ch (
                .clk        (clk),
                .rst        (rst),
                .pin        (ext_pins[c]),
                .cfg        (ext_cfg[c]),
                .edge_event (ext_event[c]),
                .stamp      (ext_stamp[c])
            );
        end
    endgenerate

    // Flatten group storage for per-source logic
    generate
        for (genvar g = 0; g < NG; g++)
        begin : g_flat
            assign flag_flat[g*GS +: GS] = grp_flag[g];
            assign en_flat[g*GS +: GS]   = grp_en[g];
            assign cpu_irq_grouped[g]    = |(grp_flag[g] & grp_en[g]) & ~grp_ack[g];
        end
    endgenerate

    // Lowest numbered enabled pending flag of the serviced group wins
    always_comb
    begin
        logic [GS-1:0] cand;
        cand       = '0;
        win_onehot = '0;
        win_bit    = '0;
        win_any    = 1'b0;
        fetch_ok   = vec_req.req && (int'(vec_req.group) < NG);
        if (fetch_ok)
            cand = grp_flag[vec_req.group] & grp_en[vec_req.group];
        for (int b = GS - 1; b >= 0; b--)
        begin
            if (cand[b])
            begin
                win_bit = 3'(b);
                win_any = 1'b1;
            end
        end
        if (win_any)
            win_onehot[win_bit] = 1'b1;
        fetch_clr = '0;
        if (win_any)
            fetch_clr = {{(`IRQ_NUM_SOURCES-GS){1'b0}}, win_onehot} << (int'(vec_req.group) * GS);
    end

    // Flags: a new request in the clearing cycle survives
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            grp_flag <= '0;
        else
        begin
            for (int g = 0; g < NG; g++)
            begin
                logic [GS-1:0] sw_clr;
                sw_clr = '0;
                if (reg_wr && blk_index(reg_addr, `REG_GRP_FLAG_BLK, NG) == 5'(g))
                    sw_clr = reg_wdata[GS-1:0];
                grp_flag[g] <= (grp_flag[g] & ~sw_clr & ~fetch_clr[g*GS +: GS]) | set_flat[g*GS +: GS];
            end
        end
    end

    // Enables, written whole per group
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            grp_en <= '0;
        else
        begin
            for (int g = 0; g < NG; g++)
            begin
                if (reg_wr && blk_index(reg_addr, `REG_GRP_EN_BLK, NG) == 5'(g))
                    grp_en[g] <= reg_wdata[GS-1:0];
            end
        end
    end

    // Group acknowledge blocks further lines of a group until software releases it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            grp_ack <= '0;
        else
        begin
            for (int g = 0; g < NG; g++)
            begin
                if (fetch_ok && int'(vec_req.group) == g)
                    grp_ack[g] <= 1'b1;
                else if (reg_wr && reg_addr == `REG_GROUP_ACK && reg_wdata[g])
                    grp_ack[g] <= 1'b0;
            end
        end
    end

    // Vector storage, flip-flops indexed by source number
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < `IRQ_NUM_SOURCES; i++)
                vec_ram[i] <= `RST_VECTOR;
        end
        else if (reg_wr && vec_hit(reg_addr))
            vec_ram[reg_addr[8:2]] <= reg_wdata[`IRQ_VEC_W-1:0];
    end

    // Vector answer one cycle after the fetch request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            vec_rsp <= '0;
        else
        begin
            vec_rsp.valid  <= fetch_ok;
            vec_rsp.source <= 7'(int'(vec_req.group) * GS + int'(win_bit));
            if (win_any)
                vec_rsp.vector <= vec_ram[7'(int'(vec_req.group) * GS + int'(win_bit))];
            else
                vec_rsp.vector <= EMPTY_VECTOR;
        end
    end

    // External input configuration
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int c = 0; c < NE; c++)
                ext_cfg[c] <= '0;
            line13_sel_timer <= 1'b0;
        end
        else
        begin
            for (int c = 0; c < NE; c++)
            begin
                if (reg_wr && blk_index(reg_addr, `REG_EXT_CFG_BLK, NE) == 5'(c))
                begin
                    ext_cfg[c].enable <= reg_wdata[`EXT_CFG_EN_BIT];
                    ext_cfg[c].rising <= reg_wdata[`EXT_CFG_RISE_BIT];
                end
            end
            if (reg_wr && reg_addr == `REG_LINE13_SEL)
                line13_sel_timer <= reg_wdata[0];
        end
    end

    // Processor lines outside the groups
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ext13_pending         <= 1'b0;
            cpu_irq_line_thirteen <= 1'b0;
            cpu_irq_line_fourteen <= 1'b0;
            cpu_nmi               <= 1'b0;
        end
        else
        begin
            if (ext_event[2])
                ext13_pending <= 1'b1;
            else if (reg_wr && reg_addr == `REG_IRQ_STATUS && reg_wdata[`ST_EXT_13_BIT])
                ext13_pending <= 1'b0;
            cpu_irq_line_thirteen <= line13_sel_timer ? timer1_irq : ext13_pending;
            cpu_irq_line_fourteen <= timer2_irq;
            cpu_nmi               <= ext_event[`IRQ_NMI_CH];
        end
    end

    // Wake conditions depend on the low-power mode in force
    always_comb
    begin
        case (lp_mode)
            irq_expand_pkg::LP_IDLE:    wake_now = |(flag_flat & en_flat);
            irq_expand_pkg::LP_STANDBY: wake_now = |ext_event;
            irq_expand_pkg::LP_HALT:    wake_now = ext_event[`IRQ_NMI_CH];
            irq_expand_pkg::LP_RUN:     wake_now = 1'b0;
            default:                    wake_now = 1'b0;
        endcase
    end

    // Wake wins over a mode write in the same cycle so no wake event is lost
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lp_mode  <= irq_expand_pkg::LP_RUN;
            cpu_wake <= 1'b0;
        end
        else
        begin
            cpu_wake <= wake_now;
            if (wake_now)
                lp_mode <= irq_expand_pkg::LP_RUN;
            else if (reg_wr && reg_addr == `REG_LP_MODE)
                lp_mode <= irq_expand_pkg::lp_mode_t'(reg_wdata[1:0]);
        end
    end

    // Sticky status with write-one-to-clear; a same-cycle event wins
    assign status_set = {wake_now, ext_event[`IRQ_NMI_CH], ext_event[2], ext_event[1], ext_event[0]};

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_status <= '0;
            irq_mask   <= '0;
        end
        else
        begin
            if (reg_wr && reg_addr == `REG_IRQ_STATUS)
                irq_status <= (irq_status & ~reg_wdata[`ST_WIDTH-1:0]) | status_set;
            else
                irq_status <= irq_status | status_set;
            if (reg_wr && reg_addr == `REG_IRQ_MASK)
                irq_mask <= reg_wdata[`ST_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read data, valid in the cycle after the strobe only; unmapped reads return zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            logic [4:0] bi;
            reg_rdata <= '0;
            if (reg_addr == `REG_LP_MODE)
                reg_rdata <= {30'h0000_0000, lp_mode};
            else if (reg_addr == `REG_IRQ_STATUS)
                reg_rdata <= 32'(irq_status);
            else if (reg_addr == `REG_IRQ_MASK)
                reg_rdata <= 32'(irq_mask);
            else if (reg_addr == `REG_LINE13_SEL)
                reg_rdata <= 32'(line13_sel_timer);
            else if (reg_addr == `REG_GROUP_ACK)
                reg_rdata <= 32'(grp_ack);
            else if (vec_hit(reg_addr))
                reg_rdata <= 32'(vec_ram[reg_addr[8:2]]);
            else
            begin
                bi = blk_index(reg_addr, `REG_GRP_EN_BLK, NG);
                if (bi != 5'h1F)
                    reg_rdata <= 32'(grp_en[bi[3:0]]);
                bi = blk_index(reg_addr, `REG_GRP_FLAG_BLK, NG);
                if (bi != 5'h1F)
                    reg_rdata <= 32'(grp_flag[bi[3:0]]);
                bi = blk_index(reg_addr, `REG_EXT_CFG_BLK, NE);
                if (bi != 5'h1F)
                    reg_rdata <= 32'(ext_cfg[bi[1:0]]);
                bi = blk_index(reg_addr, `REG_EXT_STAMP_BLK, NE);
                if (bi != 5'h1F)
                    reg_rdata <= 32'(ext_stamp[bi[1:0]]);
            end
        end
        else
            reg_rdata <= '0;
    end

endmodule // irq_expand_top
